// file: sim/fiod_cpu_model.sv
// Purpose: processor side issuing i/o cycles on the upstream_link
// Assumes: one cycle per clock
// Notes: a cycle launches one edge after the bench asks for it
`timescale 1ns/1ps
`default_nettype none
module fiod_cpu_model (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // active-low reset
    input wire fiod_pkg::fiod_req_t ask, // cycle wanted by the bench
    output fiod_pkg::fiod_req_t io_req // cycle on the link
);
    // write wins so both strobes never rise together
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            io_req <= '0;
        end else begin
            io_req <= '{addr: ask.addr, wdata: ask.wdata, wr: ask.wr, rd: ask.rd && !ask.wr};
        end
    end
endmodule
`default_nettype wire

// file: sim/fiod_decoder_asserts.sv
// Purpose: port checks for the fixed i/o decoder
// Assumes: answers land one edge after the cycle is taken
// Notes: bound onto every decoder instance
`timescale 1ns/1ps
`default_nettype none
module fiod_decoder_asserts (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire fiod_pkg::fiod_req_t io_req,
    input wire fiod_pkg::fiod_cfg_t io_cfg,
    input wire logic espi_disabled_strap,
    input wire logic [31:0] rsvd_map,
    input wire logic [31:0] func_disable,
    input wire logic [4:0] cfg_func,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_rdata_in,
    input wire logic [31:0] func_enabled_ff,
    input wire logic cfg_wr_pass_ff,
    input wire logic cfg_rd_ack_ff,
    input wire logic [31:0] cfg_rdata_ff,
    input wire fiod_pkg::fiod_fwd_t fwd_ff,
    input wire logic cpl_valid_ff,
    input wire logic [31:0] cpl_rdata_ff,
    input wire logic unclaimed_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // cycle kinds; strap held four edges covers the 2-3 cycle synchroniser
    sequence s_io; io_req.rd || io_req.wr; endsequence
    sequence s_idx; io_req.addr == 16'h0070 && rsvd_map[6:3] == 4'h0; endsequence
    sequence s_strap; espi_disabled_strap [*4]; endsequence
    sequence s_alias_off;
        s_io ##0 (io_req.addr[15:3] == 13'h000c && io_req.addr[0] && io_req.addr[2:1] != 2'h0 && !io_cfg.nmi_port_alias_enable);
    endsequence
    AST_ONE_ANSWER: assert property (s_io |=> fwd_ff.valid ^ cpl_valid_ff) else $error("not one answer");
    AST_IDLE: assert property (!(io_req.rd || io_req.wr) |=> !fwd_ff.valid && !cpl_valid_ff) else $error("spurious answer");
    AST_RD_ONES: assert property (io_req.rd |=> !cpl_valid_ff || cpl_rdata_ff == 32'hffffffff) else $error("local read data");
    AST_F30: assert property (func_enabled_ff[30]) else $error("function 30 disabled");
    AST_FDIS: assert property (1'b1 |=> func_enabled_ff == (~$past(func_disable) | 32'h40000000)) else $error("enables");
    AST_CFG_HIDE: assert property ((cfg_rd || cfg_wr) && !func_enabled_ff[cfg_func] |=> !cfg_rd_ack_ff && !cfg_wr_pass_ff && cfg_rdata_ff == 32'h0) else $error("hidden answered");
    AST_CFG_RD: assert property (cfg_rd && func_enabled_ff[cfg_func] |=> cfg_rd_ack_ff && cfg_rdata_ff == $past(cfg_rdata_in)) else $error("config read");
    AST_W70: assert property (s_idx ##0 io_req.wr |=> fwd_ff.valid && fwd_ff.tgt == fiod_pkg::FIOD_TGT_NMI_RTC) else $error("write 70");
    AST_R70: assert property (s_idx ##0 io_req.rd |=> fwd_ff.valid && fwd_ff.tgt == fiod_pkg::FIOD_TGT_RTC) else $error("read 70");
    AST_ALIAS_OFF: assert property (s_alias_off |=> cpl_valid_ff && unclaimed_ff) else $error("alias off");
    AST_STRAP: assert property (s_strap ##0 s_io |=> !(fwd_ff.valid && fwd_ff.tgt == fiod_pkg::FIOD_TGT_ESPI)) else $error("strap");
endmodule
bind fiod_decoder fiod_decoder_asserts fiod_decoder_asserts_inst (.*);
`default_nettype wire

// file: sim/fiod_decoder_bench.sv
// Purpose: self-checking bench for the fixed i/o decoder
// Assumes: cpu model adds one edge before the decoder sees a cycle
// Notes: config changes only while the pipeline is idle
`timescale 1ns/1ps
`default_nettype none
module fiod_decoder_bench;
    logic clk_sys, reset_n, strap, cfg_wr, cfg_rd, p_rd, p_wr, g;
    logic cfg_wr_pass_ff, cfg_rd_ack_ff, cpl_valid_ff, unclaimed_ff;
    logic [31:0] rsvd_map, func_disable, cfg_rdata_in, func_enabled_ff, cfg_rdata_ff, cpl_rdata_ff, p_din, en;
    logic [31:0] rng, miscompares, checks_done, cycles;
    logic [19:0] e;
    logic [4:0] cfg_func, p_fn;
    fiod_pkg::fiod_req_t ask, io_req, h1, h2;
    fiod_pkg::fiod_cfg_t io_cfg;
    fiod_pkg::fiod_fwd_t fwd_ff;
    fiod_cpu_model fiod_cpu_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .ask(ask), .io_req(io_req));
    fiod_decoder fiod_decoder_inst (.clk_sys(clk_sys), .reset_n(reset_n), .io_req(io_req), .io_cfg(io_cfg),
        .espi_disabled_strap(strap), .rsvd_map(rsvd_map), .func_disable(func_disable), .cfg_func(cfg_func),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata_in(cfg_rdata_in), .func_enabled_ff(func_enabled_ff),
        .cfg_wr_pass_ff(cfg_wr_pass_ff), .cfg_rd_ack_ff(cfg_rd_ack_ff), .cfg_rdata_ff(cfg_rdata_ff),
        .fwd_ff(fwd_ff), .cpl_valid_ff(cpl_valid_ff), .cpl_rdata_ff(cpl_rdata_ff), .unclaimed_ff(unclaimed_ff));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // expected {target, folded address}; reserved marks may hit any claimed target
    function automatic logic [19:0] exp_dec(input fiod_pkg::fiod_req_t r, input fiod_pkg::fiod_cfg_t c, input logic s);
        logic [3:0] t;
        logic [15:0] a;
        logic k;
        a = r.addr;
        t = 4'h0;
        k = 1'b0;
        if (a >= 16'h0020 && a <= 16'h003d && !a[1]) t = 4'h1;
        if (a inside {16'h0040, 16'h0042, 16'h0043, 16'h0050, 16'h0052, 16'h0053}) t = 4'h2;
        if (a inside {16'h002e, 16'h002f}) k = c.superio_decode_enable;
        if (a inside {16'h004e, 16'h004f}) k = c.microcontroller2_decode_enable;
        if (a inside {16'h0060, 16'h0064}) k = c.keyboard_decode_enable;
        if (a inside {16'h0062, 16'h0066}) k = c.microcontroller1_decode_enable;
        if (k && !s) t = 4'h6;
        if (a == 16'h0061 || (a inside {16'h0063, 16'h0065, 16'h0067} && c.nmi_port_alias_enable)) t = 4'h3;
        if (t == 4'h3) a = 16'h0061;
        if (a inside {[16'h0070:16'h0075]}) t = 4'h4;
        if (!c.rtc_upper_ram_enable && a[15:1] == 15'h0039) a = a - 16'h0002;
        if (a == 16'h0070 && r.wr) t = 4'h5;
        if (t != 4'h0 && rsvd_map[t]) t = 4'h7;
        return {t, a};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        checks_done = checks_done + 32'h1;
        if (got !== want) begin
            miscompares = miscompares + 32'h1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 32'h0 && checks_done != 32'h0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // clock, and a hang guard well above the ~1200 cycles the run needs
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 32'h1;
        if (cycles == 32'h00000bb8) begin
            miscompares = miscompares + 32'h1;
            report_and_stop;
        end
    end
    // phases of 24 cycles: config moves at j 0, traffic only in 4..21
    initial begin
        rng = 32'd3599; miscompares = 0; checks_done = 0; cycles = 0; ask = '0; io_cfg = '0;
        strap = 0; rsvd_map = 0; func_disable = 0; cfg_func = 0; cfg_wr = 0; cfg_rd = 0; cfg_rdata_in = 0;
        h1 = '0; h2 = '0; p_rd = 0; p_wr = 0; p_fn = 0; p_din = 0; reset_n = 0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int ph = 0; ph < 48; ph++) begin
            for (int j = 0; j < 24; j++) begin
                @(posedge clk_sys);
                rng = xs(rng);
                g = j > 3 && j < 22;
                if (j == 0) begin
                    io_cfg <= fiod_pkg::fiod_cfg_t'(ph == 1 ? 6'h3f : (ph == 0 ? 6'h00 : rng[5:0]));
                    strap <= ph[2];
                    rsvd_map <= {25'h0, rng[12:7] & {6{ph[0]}}, 1'b0};
                    func_disable <= ph == 1 ? 32'hffffffff : xs(rng);
                end
                ask <= '{addr: {rng[13:12] == 2'h0 ? rng[23:16] : 8'h00, 1'b0, rng[6:0]},
                    wdata: {rng[15:0], rng[31:16]}, wr: g && rng[24], rd: g && !rng[24] && rng[25]};
                cfg_rd <= g && rng[26];
                cfg_wr <= g && !rng[26] && rng[27];
                cfg_func <= rng[9] ? 5'h1e : rng[4:0];
                cfg_rdata_in <= rng ^ 32'h5a5a5a5a;
                #1;
                en = ~func_disable | 32'h40000000;
                e = exp_dec(h2, io_cfg, strap);
                if (j != 0) chk(func_enabled_ff, en);
                chk({cfg_rd_ack_ff, cfg_wr_pass_ff, cfg_rdata_ff}, {p_rd && en[p_fn], p_wr && en[p_fn], (p_rd && en[p_fn]) ? p_din : 32'h0});
                if (!(h2.rd || h2.wr)) chk({fwd_ff.valid, cpl_valid_ff}, 2'h0);
                else if (e[19:16] inside {4'h0, 4'h7}) chk({cpl_valid_ff, unclaimed_ff, fwd_ff.valid, cpl_rdata_ff}, {1'b1, e[19:16] == 4'h0, 1'b0, {32{h2.rd}}});
                else begin
                    chk({fwd_ff.valid, cpl_valid_ff, fwd_ff.tgt, fwd_ff.addr}, {2'h2, e});
                    chk({fwd_ff.wr, fwd_ff.wdata}, {h2.wr, h2.wdata});
                end
                h2 = h1;
                h1 = ask;
                p_rd = cfg_rd;
                p_wr = cfg_wr;
                p_fn = cfg_func;
                p_din = cfg_rdata_in;
            end
        end
        report_and_stop;
    end
endmodule
`default_nettype wire

// file: src/fiod_decoder.sv
// Purpose: fixed legacy i/o decoder for the platform_hub upstream_link
// Assumes: one request per cycle, strap is an asynchronous pin
// Notes: forwarded cycles go over internal_sideband_fabric as one-cycle pulses
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fiod_defs.svh"
module fiod_decoder (
    input wire logic clk_sys, // 10 mhz system clock
    input wire logic reset_n, // async active-low reset
    input wire fiod_pkg::fiod_req_t io_req, // upstream_link i/o cycle
    input wire fiod_pkg::fiod_cfg_t io_cfg, // decode enable bits
    input wire logic espi_disabled_strap, // pin strap, asynchronous
    input wire logic [31:0] rsvd_map, // per-range reserved marks, bit0 unused
    input wire logic [`FIOD_FUNC_N-1:0] func_disable, // per-function disable request
    input wire logic [4:0] cfg_func, // function addressed by a config cycle
    input wire logic cfg_wr, // config write strobe
    input wire logic cfg_rd, // config read strobe
    input wire logic [31:0] cfg_rdata_in, // read data from the addressed function
    output logic [`FIOD_FUNC_N-1:0] func_enabled_ff, // effective function enables
    output logic cfg_wr_pass_ff, // config write delivered to function
    output logic cfg_rd_ack_ff, // config read answered
    output logic [31:0] cfg_rdata_ff, // config read data
    output fiod_pkg::fiod_fwd_t fwd_ff, // sideband forward to target unit
    output logic cpl_valid_ff, // local completion of reserved or unclaimed cycle
    output logic [31:0] cpl_rdata_ff, // local completion read data
    output logic unclaimed_ff // completion was an internal termination
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic strap_meta_ff;
    logic strap_sync_ff;
    fiod_pkg::fiod_tgt_t nxt_tgt;
    logic [15:0] nxt_addr;

    // reset release through two stages
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // strap is a pin, so two flops before use
    always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            strap_meta_ff <= 1'b0;
            strap_sync_ff <= 1'b0;
        end else begin
            strap_meta_ff <= espi_disabled_strap;
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // espi target only while strap reads 0, else internal termination
    function automatic fiod_pkg::fiod_tgt_t espi_gate(input logic en, input logic strap_off);
        if (en && !strap_off) begin
            espi_gate = fiod_pkg::FIOD_TGT_ESPI;
        end else begin
            espi_gate = fiod_pkg::FIOD_TGT_NONE;
        end
    endfunction

    // pic ranges are pairs at 4-byte steps: low two address bits 0 or 1
    function automatic logic is_pic(input logic [15:0] a);
        is_pic = (a >= `FIOD_A_PIC_LO) && (a <= `FIOD_A_PIC_HI) && !a[1];
    endfunction

    // fixed range decode with alias folding
    always_comb begin
        nxt_tgt = fiod_pkg::FIOD_TGT_NONE;
        nxt_addr = io_req.addr;
        if (is_pic(io_req.addr)) begin
            nxt_tgt = fiod_pkg::FIOD_TGT_PIC;
        end else begin
            unique case (io_req.addr)
                `FIOD_A_TMR_0, `FIOD_A_TMR_2, `FIOD_A_TMR_3,
                `FIOD_A_TMR_10, `FIOD_A_TMR_12, `FIOD_A_TMR_13: begin
                    nxt_tgt = fiod_pkg::FIOD_TGT_TMR;
                end
                `FIOD_A_SUPERIO_LO, `FIOD_A_SUPERIO_HI: begin
                    nxt_tgt = espi_gate(io_cfg.superio_decode_enable, strap_sync_ff);
                end
                `FIOD_A_MC2_LO, `FIOD_A_MC2_HI: begin
                    nxt_tgt = espi_gate(io_cfg.microcontroller2_decode_enable, strap_sync_ff);
                end
                `FIOD_A_KBD_DATA, `FIOD_A_KBD_CMD: begin
                    nxt_tgt = espi_gate(io_cfg.keyboard_decode_enable, strap_sync_ff);
                end
                `FIOD_A_MC1_DATA, `FIOD_A_MC1_CMD: begin
                    nxt_tgt = espi_gate(io_cfg.microcontroller1_decode_enable, strap_sync_ff);
                end
                `FIOD_A_NMI_PORT: begin
                    nxt_tgt = fiod_pkg::FIOD_TGT_NMI;
                end
                `FIOD_A_NMI_AL1, `FIOD_A_NMI_AL2, `FIOD_A_NMI_AL3: begin
                    if (io_cfg.nmi_port_alias_enable) begin
                        nxt_tgt = fiod_pkg::FIOD_TGT_NMI;
                        nxt_addr = `FIOD_A_NMI_PORT;
                    end else begin
                        nxt_tgt = fiod_pkg::FIOD_TGT_NONE;
                    end
                end
                `FIOD_A_RTC_IDX: begin
                    nxt_tgt = io_req.wr ? fiod_pkg::FIOD_TGT_NMI_RTC : fiod_pkg::FIOD_TGT_RTC;
                end
                `FIOD_A_RTC_UIDX: begin
                    if (!io_cfg.rtc_upper_ram_enable) begin
                        nxt_addr = `FIOD_A_RTC_IDX;
                        // aliased index write also reaches nmi, as 70h does
                        nxt_tgt = io_req.wr ? fiod_pkg::FIOD_TGT_NMI_RTC : fiod_pkg::FIOD_TGT_RTC;
                    end else begin
                        nxt_tgt = fiod_pkg::FIOD_TGT_RTC;
                    end
                end
                `FIOD_A_RTC_UDATA: begin
                    nxt_tgt = fiod_pkg::FIOD_TGT_RTC;
                    if (!io_cfg.rtc_upper_ram_enable) begin
                        nxt_addr = `FIOD_A_RTC_DATA;
                    end
                end
                `FIOD_A_RTC_DATA, `FIOD_A_RTC_P74, `FIOD_A_RTC_P75: begin
                    nxt_tgt = fiod_pkg::FIOD_TGT_RTC;
                end
                default: begin
                    nxt_tgt = fiod_pkg::FIOD_TGT_NONE;
                end
            endcase
        end
        // reserved marks override, indexed by target code of the range
        if (nxt_tgt != fiod_pkg::FIOD_TGT_NONE && rsvd_map[5'(nxt_tgt)]) begin
            nxt_tgt = fiod_pkg::FIOD_TGT_RSVD;
        end
    end

    // sideband forward to the unit; one pulse per claimed cycle that is not reserved
    always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            fwd_ff <= '0;
        end else begin
            fwd_ff.valid <= (io_req.wr || io_req.rd) && (nxt_tgt != fiod_pkg::FIOD_TGT_NONE)
                && (nxt_tgt != fiod_pkg::FIOD_TGT_RSVD);
            fwd_ff.tgt <= nxt_tgt;
            fwd_ff.addr <= nxt_addr;
            fwd_ff.wdata <= io_req.wdata;
            fwd_ff.wr <= io_req.wr;
        end
    end

    // local completion: reserved reads all ones, unclaimed terminated
    always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cpl_valid_ff <= 1'b0;
            cpl_rdata_ff <= '0;
            unclaimed_ff <= 1'b0;
        end else begin
            cpl_valid_ff <= (io_req.wr || io_req.rd) && ((nxt_tgt == fiod_pkg::FIOD_TGT_NONE)
                || (nxt_tgt == fiod_pkg::FIOD_TGT_RSVD));
            // all ones also for terminated reads, so the bus never floats
            cpl_rdata_ff <= io_req.rd ? `FIOD_ALL_ONES : '0;
            unclaimed_ff <= (io_req.wr || io_req.rd) && (nxt_tgt == fiod_pkg::FIOD_TGT_NONE);
        end
    end

    // function enables; the always-on function ignores its disable
    always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            func_enabled_ff <= '1;
        end else begin
            func_enabled_ff <= ~func_disable;
            func_enabled_ff[`FIOD_ALWAYS_ON_FUNC] <= 1'b1;
        end
    end

    // config access passes only to enabled functions; hidden ones stay silent
    always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cfg_wr_pass_ff <= 1'b0;
            cfg_rd_ack_ff <= 1'b0;
            cfg_rdata_ff <= '0;
        end else begin
            cfg_wr_pass_ff <= cfg_wr && func_enabled_ff[cfg_func];
            cfg_rd_ack_ff <= cfg_rd && func_enabled_ff[cfg_func];
            cfg_rdata_ff <= (cfg_rd && func_enabled_ff[cfg_func]) ? cfg_rdata_in : '0;
        end
    end
endmodule
`default_nettype wire

// file: src/fiod_defs.svh
// Purpose: constants for the fixed legacy i/o address decoder
// Assumes: 16-bit i/o address space, byte-granular decode
// Notes: definitions only
`ifndef FIOD_DEFS_SVH
`define FIOD_DEFS_SVH
`define FIOD_ADDR_W 16
`define FIOD_DATA_W 32
`define FIOD_FUNC_N 32
`define FIOD_ALWAYS_ON_FUNC 5'h1e
`define FIOD_ALL_ONES 32'hffffffff
`define FIOD_A_SUPERIO_LO 16'h002e
`define FIOD_A_SUPERIO_HI 16'h002f
`define FIOD_A_MC2_LO 16'h004e
`define FIOD_A_MC2_HI 16'h004f
`define FIOD_A_KBD_DATA 16'h0060
`define FIOD_A_NMI_PORT 16'h0061
`define FIOD_A_MC1_DATA 16'h0062
`define FIOD_A_NMI_AL1 16'h0063
`define FIOD_A_KBD_CMD 16'h0064
`define FIOD_A_NMI_AL2 16'h0065
`define FIOD_A_MC1_CMD 16'h0066
`define FIOD_A_NMI_AL3 16'h0067
`define FIOD_A_RTC_IDX 16'h0070
`define FIOD_A_RTC_DATA 16'h0071
`define FIOD_A_RTC_UIDX 16'h0072
`define FIOD_A_RTC_UDATA 16'h0073
`define FIOD_A_RTC_P74 16'h0074
`define FIOD_A_RTC_P75 16'h0075
`define FIOD_A_PIC_LO 16'h0020
`define FIOD_A_PIC_HI 16'h003d
`define FIOD_A_TMR_0 16'h0040
`define FIOD_A_TMR_2 16'h0042
`define FIOD_A_TMR_3 16'h0043
`define FIOD_A_TMR_10 16'h0050
`define FIOD_A_TMR_12 16'h0052
`define FIOD_A_TMR_13 16'h0053
`endif

// file: src/fiod_pkg.sv
// Purpose: types for the fixed legacy i/o address decoder
// Assumes: used with fiod_defs.svh
// Notes: target codes are one-hot-free binary
package fiod_pkg;
    typedef enum logic [3:0] {
        FIOD_TGT_NONE = 4'h0, // terminated internally
        FIOD_TGT_PIC = 4'h1,
        FIOD_TGT_TMR = 4'h2,
        FIOD_TGT_NMI = 4'h3,
        FIOD_TGT_RTC = 4'h4,
        FIOD_TGT_NMI_RTC = 4'h5, // write to both units
        FIOD_TGT_ESPI = 4'h6,
        FIOD_TGT_RSVD = 4'h7 // completed by the hub with all ones
    } fiod_tgt_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fiod_req_t;

    typedef struct packed {
        logic valid;
        fiod_tgt_t tgt;
        logic [15:0] addr; // address after alias folding
        logic [31:0] wdata;
        logic wr;
    } fiod_fwd_t;

    typedef struct packed {
        logic superio_decode_enable;
        logic microcontroller2_decode_enable;
        logic keyboard_decode_enable;
        logic microcontroller1_decode_enable;
        logic nmi_port_alias_enable;
        logic rtc_upper_ram_enable;
    } fiod_cfg_t;
endpackage
